// ===== bench/test_tpwm_top.sv
// Self-checking bench for the timer-based PWM generator.
`timescale 1ns/100ps
`default_nettype none
module test_tpwm_top
  import tpwm_pkg::*;
;
  logic            clk, reset, counterReset;
  tpwm_ctrl_t      ctrl;
  tpwm_act_t [6:0] matchAct;
  logic [31:0]     prescaleLimit, matchWrData, count, prescaleCount;
  logic [1:0]      capIn;
  logic [6:0]      matchWrEn, matchRelease, flagClear, matchFlag, releasePending;
  logic [5:0]      doubleEdge, outEnable, constLow, pwmOut;
  logic [15:0]     hiLen [6];
  logic [15:0]     perLen [6];
  int              miscompares, n_tests, cycles;
  tpwm_top u_tpwm_top (.clk(clk), .reset(reset), .ctrl(ctrl), .prescaleLimit(prescaleLimit),
    .counterReset(counterReset), .capIn(capIn), .matchAct(matchAct), .matchWrEn(matchWrEn),
    .matchWrData(matchWrData), .matchRelease(matchRelease), .doubleEdge(doubleEdge),
    .outEnable(outEnable), .constLow(constLow), .flagClear(flagClear), .pwmOut(pwmOut),
    .count(count), .prescaleCount(prescaleCount), .matchFlag(matchFlag),
    .releasePending(releasePending));
  tpwm_load u_tpwm_load (.clk(clk), .pwmOut(pwmOut), .hiLen(hiLen), .perLen(perLen));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(int idx, logic [31:0] v);
    matchWrEn <= 7'h01 << idx;
    matchWrData <= v;
    tick(1);
    matchWrEn <= 7'h00;
    tick(1);
  endtask
  task automatic rel(logic [6:0] m);
    matchRelease <= m;
    tick(1);
    matchRelease <= 7'h00;
    tick(1);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_timer;
    logic [31:0] c0;
    ctrl.runEn <= 1'b1;
    prescaleLimit <= 32'h00000002;
    tick(5);
    c0 = count;
    tick(30);
    check("timerCount", count - c0, 32'h0000000A);
    check("pwmIdle", pwmOut, 32'h00000000);
  endtask
  task automatic t_capture;
    logic [31:0] c0;
    prescaleLimit <= 32'h00000000;
    counterReset <= 1'b1;
    tick(1);
    counterReset <= 1'b0;
    ctrl.capSel <= 2'h1;
    for (int m = 1; m < 4; m++) begin
      ctrl.src <= tpwm_src_t'(m);
      tick(3);
      c0 = count;
      repeat (5) begin
        capIn <= 2'h2;
        tick(4);
        capIn <= 2'h1;
        tick(4);
      end
      tick(4);
      check("edgeCount", count - c0, (m == 3) ? 32'h0000000A : 32'h00000005);
    end
  endtask
  task automatic t_stop_flag;
    logic [31:0] c0;
    ctrl.runEn <= 1'b0;
    ctrl.src <= TPWM_SRC_CLK;
    counterReset <= 1'b1;
    matchAct <= 21'h000005;
    tick(2);
    counterReset <= 1'b0;
    ctrl.runEn <= 1'b1;
    tick(10);
    c0 = count;
    tick(10);
    check("stopHeld", count, c0);
    check("stopEarly", c0 < 2, 32'h00000001);
    check("flagSet", matchFlag[0], 32'h00000001);
    ctrl.runEn <= 1'b0;
    tick(5);
    check("flagSticky", matchFlag[0], 32'h00000001);
    flagClear <= 7'h01;
    tick(1);
    flagClear <= 7'h00;
    tick(2);
    check("flagCleared", matchFlag[0], 32'h00000000);
  endtask
  task automatic t_pwm;
    logic seen;
    counterReset <= 1'b1;
    matchAct <= 21'h000002;
    ctrl.pwmEn <= 1'b1;
    ctrl.runEn <= 1'b1;
    outEnable <= 6'h3F;
    tick(2);
    counterReset <= 1'b0;
    wr(0, 32'h00000009);
    wr(1, 32'h00000003);
    wr(2, 32'h00000002);
    wr(3, 32'h00000006);
    rel(7'h0F);
    tick(40);
    check("period0", perLen[0], 32'h0000000A);
    check("high0", hiLen[0], 32'h00000004);
    check("period1", perLen[1], 32'h0000000A);
    check("high1", hiLen[1], 32'h00000003);
    wr(1, 32'h00000006);
    tick(40);
    check("highHeld", hiLen[0], 32'h00000004);
    rel(7'h02);
    tick(40);
    check("highNew", hiLen[0], 32'h00000007);
    doubleEdge <= 6'h04;
    tick(40);
    check("posPulse", hiLen[2], 32'h00000004);
    wr(2, 32'h00000006);
    wr(3, 32'h00000002);
    rel(7'h0C);
    tick(40);
    check("negPulse", hiLen[2], 32'h00000006);
    check("period2", perLen[2], 32'h0000000A);
    constLow <= 6'h01;
    tick(12);
    seen = 1'b0;
    repeat (20) begin
      tick(1);
      seen = seen | pwmOut[0];
    end
    check("constLow", seen, 32'h00000000);
    ctrl.pwmEn <= 1'b0;
    tick(3);
    check("pwmOff", pwmOut, 32'h00000000);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    reset = 1'b1;
    ctrl = '0;
    prescaleLimit = '0;
    counterReset = 1'b0;
    capIn = 2'h0;
    matchAct = '0;
    matchWrEn = 7'h00;
    matchWrData = '0;
    matchRelease = 7'h00;
    doubleEdge = 6'h00;
    outEnable = 6'h00;
    constLow = 6'h00;
    flagClear = 7'h00;
    tick(2);
    reset <= 1'b0;
    tick(1);
    t_timer();
    t_capture();
    t_stop_flag();
    t_pwm();
    final_report();
  end
endmodule
`default_nettype wire

// ===== bench/tpwm_load.sv
// Load model that measures high time and period of each output.
`timescale 1ns/100ps
`default_nettype none
module tpwm_load (
  input  wire logic       clk,
  input  wire logic [5:0] pwmOut,
  output logic [15:0]     hiLen [6],
  output logic [15:0]     perLen [6]
);
  logic [15:0] since [6];
  logic [5:0]  prev;
  always_ff @(posedge clk) begin
    prev <= pwmOut;
    for (int i = 0; i < 6; i++) begin
      since[i] <= (pwmOut[i] & ~prev[i]) ? 16'h0001 : since[i] + 16'h0001;
      if (pwmOut[i] & ~prev[i]) perLen[i] <= since[i];
      if (~pwmOut[i] & prev[i]) hiLen[i] <= since[i];
    end
  end
endmodule
`default_nettype wire

// ===== bench/tpwm_top_assertions.sv
// Port-level assertions for the timer-based PWM generator.
`timescale 1ns/100ps
`default_nettype none
module tpwm_top_assertions
  import tpwm_pkg::*;
#(parameter int NUM_MATCH = 7, parameter int NUM_OUT = 6,
  parameter int CNT_W = 32, parameter int PRE_W = 32) (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire tpwm_ctrl_t                 ctrl,
  input wire logic [PRE_W-1:0]           prescaleLimit,
  input wire logic                       counterReset,
  input wire tpwm_act_t [NUM_MATCH-1:0]  matchAct,
  input wire logic [NUM_MATCH-1:0]       flagClear,
  input wire logic [NUM_OUT-1:0]         constLow,
  input wire logic [NUM_OUT-1:0]         doubleEdge,
  input wire logic [NUM_OUT-1:0]         pwmOut,
  input wire logic [CNT_W-1:0]           count,
  input wire logic [PRE_W-1:0]           prescaleCount,
  input wire logic [NUM_MATCH-1:0]       matchFlag
);
  logic [NUM_MATCH-1:0] irqEn;
  always_comb begin
    for (int i = 0; i < NUM_MATCH; i++) irqEn[i] = matchAct[i].irq;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_pwm_off;
    !ctrl.pwmEn && !$past(ctrl.pwmEn) |-> pwmOut == '0;
  endproperty
  property p_const_low;
    (pwmOut & ~doubleEdge & constLow & $past(constLow & ~doubleEdge)) == '0;
  endproperty
  property p_cnt_reset;
    counterReset |=> count == '0 && prescaleCount == '0;
  endproperty
  property p_cnt_step;
    $changed(count) |-> count == '0 || count == $past(count) + 1'b1;
  endproperty
  property p_pre_wrap;
    $changed(count) && count != '0 |-> $past(prescaleCount) == $past(prescaleLimit);
  endproperty
  property p_flag_hold;
    ($past(matchFlag) & ~$past(flagClear) & ~matchFlag) == '0;
  endproperty
  property p_flag_cause;
    (matchFlag & ~$past(matchFlag) & ~$past(irqEn)) == '0;
  endproperty
  property p_run_off;
    !ctrl.runEn && !$past(ctrl.runEn) ##1 !counterReset |-> $stable(count);
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("output high outside pwm mode");
  a_const_low: assert property (p_const_low) else $error("constant low output rose");
  a_cnt_reset: assert property (p_cnt_reset) else $error("counter not held at zero");
  a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");
  a_pre_wrap: assert property (p_pre_wrap) else $error("count moved before limit");
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped uncleared");
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without irq");
  a_run_off: assert property (p_run_off) else $error("counter moved while off");
  c_flag: cover property ($rose(matchFlag[0]));
  c_pulse: cover property ($rose(pwmOut[2]));
  c_hold: cover property (counterReset ##1 !counterReset);
endmodule
bind tpwm_top tpwm_top_assertions #(.NUM_MATCH(NUM_MATCH), .NUM_OUT(NUM_OUT),
  .CNT_W(CNT_W), .PRE_W(PRE_W)) u_chk (.clk(clk), .reset(reset), .ctrl(ctrl),
  .prescaleLimit(prescaleLimit), .counterReset(counterReset), .matchAct(matchAct),
  .flagClear(flagClear), .constLow(constLow), .doubleEdge(doubleEdge),
  .pwmOut(pwmOut), .count(count), .prescaleCount(prescaleCount), .matchFlag(matchFlag));
`default_nettype wire

// ===== hw/tpwm_match_bank.sv
// Shadow and active match registers with cycle-synchronised release.
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_params.svh"

module tpwm_match_bank
  import tpwm_pkg::*;
#(
  parameter int NUM = 7,
  parameter int W   = 32
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [NUM-1:0]   wrEn,
  input  wire logic [W-1:0]     wrData,
  input  wire logic [NUM-1:0]   relArm,
  input  wire logic             cycleStart,
  output logic [NUM*W-1:0]      active,
  output logic [NUM-1:0]        pending
);

  logic [W-1:0]   shadow_ff [NUM];
  logic [W-1:0]   nxt_shadow [NUM];
  logic [W-1:0]   active_ff [NUM];
  logic [W-1:0]   nxt_active [NUM];
  logic [NUM-1:0] pending_ff;
  logic [NUM-1:0] nxt_pending;

  ////////////////////////////////////////////////////////////////////////////
  // A release only arms the copy; the copy lands at the next cycle start.
  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      nxt_shadow[i] = wrEn[i] ? wrData : shadow_ff[i];
      nxt_active[i] = active_ff[i];
      nxt_pending[i] = pending_ff[i] | relArm[i];
      if (cycleStart && pending_ff[i]) begin
        nxt_active[i]  = shadow_ff[i];
        nxt_pending[i] = relArm[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM; i++) begin
      if (reset) begin
        shadow_ff[i] <= `TPWM_MATCH_RESET;
        active_ff[i] <= `TPWM_MATCH_RESET;
      end else begin
        shadow_ff[i] <= nxt_shadow[i];
        active_ff[i] <= nxt_active[i];
      end
    end
    if (reset) begin
      pending_ff <= '0;
    end else begin
      pending_ff <= nxt_pending;
    end
  end

  generate
    for (genvar g = 0; g < NUM; g++) begin : gActive
      assign active[g*W +: W] = active_ff[g];
    end
  endgenerate

  assign pending = pending_ff;

endmodule
`default_nettype wire

// ===== hw/tpwm_top.sv
// Timer-based PWM generator: prescaler, counter, match actions and outputs.
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_params.svh"

// Behaviour
// - Counter clears when it equals the period match value in PWM mode.
// - Single-edge outputs rise at period match; own match sets falling edge.
// - Single-edge output programmed constant low never rises.
// - Double-edge output uses two match registers, one per edge.
// - Rise before fall gives positive pulse; fall before rise gives negative.
// - Seven match registers feed up to six single or three double outputs.
// - Each match may halt the counter, with optional interrupt.
// - Each match may clear the counter, with optional interrupt, else continue.
// - Period and widths are whole ticks; all outputs share one period.
// - New match values reach outputs only at cycle start.
// - Counter counts the clock or edges of a selected capture input.
// - Without PWM mode it is a plain timer and outputs stay low.
module tpwm_top
  import tpwm_pkg::*;
#(
  parameter int NUM_MATCH = `TPWM_NUM_MATCH,
  parameter int NUM_OUT   = `TPWM_NUM_OUT,
  parameter int CNT_W     = `TPWM_CNT_W,
  parameter int PRE_W     = `TPWM_PRE_W,
  parameter int CAP_W     = `TPWM_CAP_W
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire tpwm_ctrl_t               ctrl,
  input  wire logic [PRE_W-1:0]         prescaleLimit,
  input  wire logic                     counterReset,
  input  wire logic [CAP_W-1:0]         capIn,
  input  wire tpwm_act_t [NUM_MATCH-1:0] matchAct,
  input  wire logic [NUM_MATCH-1:0]     matchWrEn,
  input  wire logic [CNT_W-1:0]         matchWrData,
  input  wire logic [NUM_MATCH-1:0]     matchRelease,
  input  wire logic [NUM_OUT-1:0]       doubleEdge,
  input  wire logic [NUM_OUT-1:0]       outEnable,
  input  wire logic [NUM_OUT-1:0]       constLow,
  input  wire logic [NUM_MATCH-1:0]     flagClear,
  output logic [NUM_OUT-1:0]            pwmOut,
  output logic [CNT_W-1:0]              count,
  output logic [PRE_W-1:0]              prescaleCount,
  output logic [NUM_MATCH-1:0]          matchFlag,
  output logic [NUM_MATCH-1:0]          releasePending
);

  localparam int LAST_CAP = (1 << CAP_W) - 1;

  logic [CNT_W-1:0]        cnt_ff;
  logic [CNT_W-1:0]        nxt_cnt;
  logic [PRE_W-1:0]        pre_ff;
  logic [PRE_W-1:0]        nxt_pre;
  logic                    run_ff;
  logic                    nxt_run;
  logic [CAP_W-1:0]        capPrev_ff;
  logic [NUM_OUT-1:0]      out_ff;
  logic [NUM_OUT-1:0]      nxt_out;
  logic [NUM_MATCH-1:0]    flag_ff;
  logic [NUM_MATCH-1:0]    nxt_flag;
  logic [NUM_MATCH-1:0]    pend_ff;
  logic [NUM_MATCH*CNT_W-1:0] activeMatch;
  logic [NUM_MATCH-1:0]    pendWire;
  logic [NUM_MATCH-1:0]    hit;
  logic                    tick;
  logic                    advance;
  logic                    capEdge;
  logic                    cycleStart;
  logic                    anyStop;
  logic                    anyClear;
  logic                    stopLatch_ff;
  logic                    nxt_stopLatch;

  ////////////////////////////////////////////////////////////////////////////
  // Active match values change only when the counter wraps to a new cycle.
  tpwm_match_bank #(
    .NUM (NUM_MATCH),
    .W   (CNT_W)
  ) u_tpwm_match_bank (
    .clk        (clk),
    .reset      (reset),
    .wrEn       (matchWrEn),
    .wrData     (matchWrData),
    .relArm     (matchRelease),
    .cycleStart (cycleStart),
    .active     (activeMatch),
    .pending    (pendWire)
  );

  function automatic logic [CNT_W-1:0] matchVal(input logic [NUM_MATCH*CNT_W-1:0] v,
                                                input int idx);
    matchVal = v[idx*CNT_W +: CNT_W];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Count source selection and match detection.
  always_comb begin
    logic cur;
    logic prv;
    cur = 1'b0;
    prv = 1'b0;
    for (int c = 0; c <= LAST_CAP; c++) begin
      if (ctrl.capSel == CAP_W'(c)) begin
        cur = capIn[c];
        prv = capPrev_ff[c];
      end
    end
    unique case (ctrl.src)
      TPWM_SRC_CLK:  capEdge = 1'b1;
      TPWM_SRC_RISE: capEdge = cur & ~prv;
      TPWM_SRC_FALL: capEdge = ~cur & prv;
      TPWM_SRC_BOTH: capEdge = cur ^ prv;
    endcase
  end

  assign tick    = run_ff && !counterReset && capEdge;
  assign advance = tick && (pre_ff == prescaleLimit);

  always_comb begin
    anyStop  = 1'b0;
    anyClear = 1'b0;
    for (int m = 0; m < NUM_MATCH; m++) begin
      hit[m] = run_ff && (cnt_ff == matchVal(activeMatch, m));
      if (hit[m] && matchAct[m].stop) begin
        anyStop = 1'b1;
      end
      if (hit[m] && matchAct[m].clear) begin
        anyClear = 1'b1;
      end
    end
    if (ctrl.pwmEn && hit[`TPWM_PERIOD_IDX]) begin
      anyClear = 1'b1;
    end
  end

  assign cycleStart = advance && anyClear;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler, counter and run state.
  always_comb begin
    nxt_pre = pre_ff;
    nxt_cnt = cnt_ff;
    nxt_run = ctrl.runEn && !(anyStop && advance);
    if (counterReset) begin
      nxt_pre = '0;
      nxt_cnt = '0;
    end else if (advance) begin
      nxt_pre = '0;
      if (anyClear) begin
        nxt_cnt = '0;
      end else begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end else if (tick) begin
      nxt_pre = pre_ff + PRE_W'(1);
    end
    if (!ctrl.runEn) begin
      nxt_run = 1'b0;
    end else if (!run_ff && !(anyStop && stopLatch_ff)) begin
      nxt_run = 1'b1;
    end
  end

  // A stopped counter stays stopped until software drops and raises runEn.
  always_comb begin
    nxt_stopLatch = stopLatch_ff;
    if (!ctrl.runEn) begin
      nxt_stopLatch = 1'b0;
    end else if (anyStop && advance) begin
      nxt_stopLatch = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pre_ff       <= `TPWM_PRE_RESET;
      cnt_ff       <= `TPWM_CNT_RESET;
      run_ff       <= 1'b0;
      stopLatch_ff <= 1'b0;
      capPrev_ff   <= '0;
    end else begin
      pre_ff       <= nxt_pre;
      cnt_ff       <= nxt_cnt;
      run_ff       <= nxt_run && !nxt_stopLatch;
      stopLatch_ff <= nxt_stopLatch;
      capPrev_ff   <= capIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output waveforms. Output n uses match n+1 as its edge; double-edge
  // output n (n > 0) uses match n as rise and n+1 as fall; output 0 is always single-edge.
  always_comb begin
    for (int n = 0; n < NUM_OUT; n++) begin
      nxt_out[n] = out_ff[n];
      if (!ctrl.pwmEn || !outEnable[n]) begin
        nxt_out[n] = 1'b0;
      end else if (advance) begin
        if (doubleEdge[n] && n > 0) begin
          if (hit[n]) begin
            nxt_out[n] = 1'b1;
          end
          if (hit[n+1]) begin
            nxt_out[n] = 1'b0;
          end
        end else begin
          if (cycleStart && !constLow[n]) begin
            nxt_out[n] = 1'b1;
          end
          if (hit[n+1] || constLow[n]) begin
            nxt_out[n] = 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky match flags; a new hit wins over a clear in the same cycle.
  always_comb begin
    for (int m = 0; m < NUM_MATCH; m++) begin
      nxt_flag[m] = (flag_ff[m] && !flagClear[m]) ||
                    (advance && hit[m] && matchAct[m].irq);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_ff  <= '0;
      flag_ff <= '0;
      pend_ff <= '0;
    end else begin
      out_ff  <= nxt_out;
      flag_ff <= nxt_flag;
      pend_ff <= pendWire;
    end
  end

  assign pwmOut         = out_ff;
  assign count          = cnt_ff;
  assign prescaleCount  = pre_ff;
  assign matchFlag      = flag_ff;
  assign releasePending = pend_ff;

endmodule
`default_nettype wire

// ===== pkg/tpwm_params.svh
// Constants for the timer-based PWM generator.
`ifndef TPWM_PARAMS_SVH
`define TPWM_PARAMS_SVH

`define TPWM_NUM_MATCH      7
`define TPWM_NUM_OUT        6
`define TPWM_CNT_W          32
`define TPWM_PRE_W          32
`define TPWM_CAP_W          2
`define TPWM_CNT_RESET      32'h00000000
`define TPWM_PRE_RESET      32'h00000000
`define TPWM_MATCH_RESET    32'h00000000
`define TPWM_PERIOD_IDX     0

`endif

// ===== pkg/tpwm_pkg.sv
// Types shared by the timer-based PWM generator.
package tpwm_pkg;

  typedef enum logic [1:0] {
    TPWM_SRC_CLK  = 2'h0,
    TPWM_SRC_RISE = 2'h1,
    TPWM_SRC_FALL = 2'h2,
    TPWM_SRC_BOTH = 2'h3
  } tpwm_src_t;

  typedef struct packed {
    logic        stop;
    logic        clear;
    logic        irq;
  } tpwm_act_t;

  typedef struct packed {
    logic        runEn;
    logic        pwmEn;
    tpwm_src_t   src;
    logic [1:0]  capSel;
  } tpwm_ctrl_t;

endpackage
